// File: hdl/cfrs_map.svh
`ifndef CFRS_MAP_SVH
`define CFRS_MAP_SVH

// ----------------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------------
`define CFRS_CLK_PERIOD_NS        10
`define CFRS_RELEASE_CYCLES       1024
`define CFRS_RELEASE_REF_CYCLES   512
`define CFRS_REQ_MIN_PULSE_NS     10
`define CFRS_REQ_MIN_PULSE_CYC    ((`CFRS_REQ_MIN_PULSE_NS + `CFRS_CLK_PERIOD_NS - 1) / `CFRS_CLK_PERIOD_NS)
`define CFRS_PD_RECOVER_CYCLES    3
`define CFRS_LOCK_EDGES           4
`define CFRS_MIN_PERIOD           8

// ----------------------------------------------------------------------------
// field positions of the phase chain
// ----------------------------------------------------------------------------
`define CFRS_PH_DOUBLE_BIT        0
`define CFRS_PH_BASE_BIT          1
`define CFRS_PH_HALF_BIT          2
`define CFRS_PH_WIDTH             3
`define CFRS_TICK_SHIFT           3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CFRS_RST_DRIVE            1'b1

`endif

// File: hdl/cfrs_pkg.sv
package cfrs_pkg;

	typedef enum logic [1:0] {
		LS_ACQ  = 2'b00,
		LS_LOCK = 2'b01,
		LS_BYP  = 2'b10
	} cfrs_loop_e;

endpackage

// File: hdl/cfrs_release_counter.sv
`timescale 1ns/1ps
`include "cfrs_map.svh"

module cfrs_release_counter
	import cfrs_pkg::*;
#(
	parameter int CW    = 11,
	parameter int COUNT = `CFRS_RELEASE_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic hold,
	input  wire logic step,
	output logic      drive
);

	logic [CW-1:0] cnt;

	// ------------------------------------------------------------------------
	// count base-clock rising edges once hold has gone away
	// ------------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt   <= '0;
			drive <= `CFRS_RST_DRIVE;
		end else if (hold) begin
			cnt   <= '0;
			drive <= 1'b1;
		end else if (drive && step) begin
			if (cnt == CW'(COUNT - 1)) begin
				drive <= 1'b0;
			end else begin
				cnt <= cnt + CW'(1);
			end
		end
	end

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	restart_on_hold_a: assert property (hold |=> (cnt == '0) && drive)
		else $error("release counter did not restart on hold");
	no_early_release_a: assert property ($fell(drive) |-> $past(cnt) == CW'(COUNT - 1))
		else $error("release before full count");

endmodule

// File: hdl/cfrs_top.sv
// Summary of operation
// - inverted clock is complement of base clock 2
// - double-rate clock twice base, edges aligned
// - half-rate clock fed back against reference
// - base clock fixed at twice reference
// - loop enable low bypasses oscillator, follows reference
// - request high at power-up: low until lock
// - release 1024 base cycles after lock, never drive high
// - request low at power-up holds output low
// - request pulse holds output low 1024 cycles
// - clocks keep running during reset request
// - release 1024 cycles after request rises
// - power-down stops double-rate and two base clocks
// - outputs aligned within 3 cycles after power-down
// - power-down forces stopped outputs low
`timescale 1ns/1ps
`include "cfrs_map.svh"

module cfrs_top
	import cfrs_pkg::*;
#(
	parameter int PW          = 16,
	parameter int LOCK_EDGES  = `CFRS_LOCK_EDGES,
	parameter int RELEASE_CNT = `CFRS_RELEASE_CYCLES
) (
	input  wire logic       REF_CLK,
	input  wire logic       SYS_RST,
	input  wire logic       SYNC_IN,
	input  wire logic       LOOP_EN,
	input  wire logic       RESET_REQ_N,
	input  wire logic       OUTPUT_POWERDOWN,
	output logic [2:0]      BASE_CLOCK_OUT,
	output logic            INVERTED_CLOCK_OUT,
	output logic            DOUBLE_RATE_CLOCK_OUT,
	output logic            HALF_RATE_CLOCK_OUT,
	output logic            RESET_LOCK_O,
	output logic            RESET_LOCK_OE
);

	localparam int TW = PW - `CFRS_TICK_SHIFT;
	localparam int SW = $clog2(LOCK_EDGES + 1);

	cfrs_loop_e                    state;
	cfrs_loop_e                    next_state;
	logic                          sync_d;
	logic                          ref_rise;
	logic [PW-1:0]                 pcnt;
	logic [PW-1:0]                 period;
	logic [PW-1:0]                 next_period;
	logic                          period_match;
	logic                          overflow;
	logic [SW-1:0]                 stable;
	logic [TW-1:0]                 tcnt;
	logic [TW-1:0]                 tick_last;
	logic                          tick;
	logic [`CFRS_PH_WIDTH-1:0]     ph;
	logic [`CFRS_PH_WIDTH-1:0]     next_ph;
	logic                          base_step;
	logic                          half_byp;
	logic                          locked;
	logic                          hold;
	logic                          next_base;
	logic                          next_double;
	logic                          next_half;

	// ------------------------------------------------------------------------
	// reference edge and period measurement
	// ------------------------------------------------------------------------
	assign ref_rise     = SYNC_IN & ~sync_d;
	assign next_period  = pcnt + PW'(1);
	assign period_match = (next_period == period) && (next_period >= PW'(`CFRS_MIN_PERIOD));
	assign overflow     = &pcnt;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			sync_d <= 1'b0;
		end else begin
			sync_d <= SYNC_IN;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			pcnt   <= '0;
			period <= '0;
		end else if (ref_rise) begin
			pcnt   <= '0;
			period <= next_period;
		end else if (!overflow) begin
			pcnt <= next_period;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			stable <= '0;
		end else if (overflow || (ref_rise && !period_match)) begin
			stable <= '0;
		end else if (ref_rise && stable != SW'(LOCK_EDGES)) begin
			stable <= stable + SW'(1);
		end
	end

	// ------------------------------------------------------------------------
	// loop state
	// ------------------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			LS_ACQ: begin
				if (!LOOP_EN) next_state = LS_BYP;
				else if (stable == SW'(LOCK_EDGES)) next_state = LS_LOCK;
			end
			LS_LOCK: begin
				if (!LOOP_EN) next_state = LS_BYP;
				else if (overflow || (ref_rise && !period_match)) next_state = LS_ACQ;
			end
			LS_BYP: begin
				if (LOOP_EN) next_state = LS_ACQ;
			end
			default: next_state = LS_ACQ;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state <= LS_ACQ;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------------
	// divider chain: eight ticks per reference period
	// ------------------------------------------------------------------------
	assign tick_last = (period[PW-1:`CFRS_TICK_SHIFT] == '0) ? '0
	                 : period[PW-1:`CFRS_TICK_SHIFT] - TW'(1);
	assign tick      = (tcnt >= tick_last);

	always_comb begin
		next_ph = ph;
		if (ref_rise) begin
			next_ph = '0;
		end else if (tick) begin
			next_ph = ph + `CFRS_PH_WIDTH'(1);
		end
	end

	assign base_step = ph[`CFRS_PH_BASE_BIT] & ~next_ph[`CFRS_PH_BASE_BIT];

	// chain ignores power-down so stopped outputs resume in phase
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			tcnt <= '0;
			ph   <= '0;
		end else begin
			tcnt <= (ref_rise || tick) ? '0 : tcnt + TW'(1);
			ph   <= next_ph;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			half_byp <= 1'b0;
		end else if (ref_rise) begin
			half_byp <= ~half_byp;
		end
	end

	// ------------------------------------------------------------------------
	// clock outputs
	// ------------------------------------------------------------------------
	always_comb begin
		if (!LOOP_EN) begin
			next_base   = SYNC_IN;
			next_double = SYNC_IN;
			next_half   = ref_rise ? ~half_byp : half_byp;
		end else begin
			next_base   = ~next_ph[`CFRS_PH_BASE_BIT];
			next_double = ~next_ph[`CFRS_PH_DOUBLE_BIT];
			next_half   = ~next_ph[`CFRS_PH_HALF_BIT];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			BASE_CLOCK_OUT        <= '0;
			INVERTED_CLOCK_OUT    <= 1'b1;
			DOUBLE_RATE_CLOCK_OUT <= 1'b0;
			HALF_RATE_CLOCK_OUT   <= 1'b0;
		end else begin
			BASE_CLOCK_OUT[2]     <= next_base;
			INVERTED_CLOCK_OUT    <= ~next_base;
			HALF_RATE_CLOCK_OUT   <= next_half;
			if (OUTPUT_POWERDOWN) begin
				BASE_CLOCK_OUT[1:0]   <= 2'h0;
				DOUBLE_RATE_CLOCK_OUT <= 1'b0;
			end else begin
				BASE_CLOCK_OUT[1:0]   <= {2{next_base}};
				DOUBLE_RATE_CLOCK_OUT <= next_double;
			end
		end
	end

	// ------------------------------------------------------------------------
	// reset and lock indicator, open drain
	// ------------------------------------------------------------------------
	assign locked       = (state == LS_LOCK) || (state == LS_BYP);
	assign hold         = !locked || !RESET_REQ_N;
	assign RESET_LOCK_O = 1'b0;

	cfrs_release_counter #(
		.CW    ($clog2(RELEASE_CNT)),
		.COUNT (RELEASE_CNT)
	) u_release (
		.clk   (REF_CLK),
		.rst   (SYS_RST),
		.hold  (hold),
		.step  (base_step),
		.drive (RESET_LOCK_OE)
	);

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	logic [1:0]  rise_cnt;
	logic        win_ok;
	logic [11:0] rel_cnt;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			rise_cnt <= '0;
			win_ok   <= 1'b0;
		end else if (ref_rise) begin
			rise_cnt <= '0;
			win_ok   <= (state == LS_LOCK) && LOOP_EN;
		end else if (BASE_CLOCK_OUT[2] && !$past(BASE_CLOCK_OUT[2]) && rise_cnt != 2'h3) begin
			rise_cnt <= rise_cnt + 2'h1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST || hold) begin
			rel_cnt <= '0;
		end else if (base_step && rel_cnt != 12'hFFF) begin
			rel_cnt <= rel_cnt + 12'h1;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	inverted_clock_a: assert property (INVERTED_CLOCK_OUT == ~BASE_CLOCK_OUT[2])
		else $error("inverted clock not complement of base");
	double_rate_edge_a: assert property (
		($past(state) == LS_LOCK) && $past(LOOP_EN) && $past(!OUTPUT_POWERDOWN)
		&& $rose(BASE_CLOCK_OUT[2]) |-> $rose(DOUBLE_RATE_CLOCK_OUT))
		else $error("double-rate edge not aligned to base edge");
	half_feedback_a: assert property (
		(state == LS_LOCK) && LOOP_EN && ref_rise
		|=> HALF_RATE_CLOCK_OUT && BASE_CLOCK_OUT[2])
		else $error("half-rate feedback not aligned to reference");
	fixed_ratio_a: assert property (
		ref_rise && win_ok && (state == LS_LOCK) && LOOP_EN |-> rise_cnt == 2'h2)
		else $error("base clock not twice reference");
	test_mode_a: assert property (!LOOP_EN |=> BASE_CLOCK_OUT[2] == $past(SYNC_IN))
		else $error("bypass output does not follow reference");
	hold_low_a: assert property (hold |=> RESET_LOCK_OE)
		else $error("reset output released while held");
	never_high_a: assert property (RESET_LOCK_O == 1'b0)
		else $error("reset output driven high");
	release_count_a: assert property ($fell(RESET_LOCK_OE) |-> rel_cnt == 12'(RELEASE_CNT))
		else $error("release not after full base-cycle count");
	clocks_in_reset_a: assert property (
		!RESET_REQ_N && (state == LS_LOCK) && LOOP_EN && ref_rise
		|=> HALF_RATE_CLOCK_OUT && BASE_CLOCK_OUT[2])
		else $error("clocks disturbed by reset request");
	powerdown_low_a: assert property (
		OUTPUT_POWERDOWN |=> !DOUBLE_RATE_CLOCK_OUT && (BASE_CLOCK_OUT[1:0] == 2'h0))
		else $error("power-down outputs not held low");
	pd_recover_a: assert property (
		$fell(OUTPUT_POWERDOWN) |-> ##[1:3] ((BASE_CLOCK_OUT[0] == BASE_CLOCK_OUT[2])
		&& (BASE_CLOCK_OUT[1] == BASE_CLOCK_OUT[2])))
		else $error("outputs not aligned after power-down");
	chain_runs_a: assert property (
		OUTPUT_POWERDOWN && (state == LS_LOCK) && LOOP_EN && ref_rise
		|=> HALF_RATE_CLOCK_OUT && BASE_CLOCK_OUT[2])
		else $error("divider chain stopped in power-down");
	pd_double_a: assert property (
		$fell(OUTPUT_POWERDOWN) && LOOP_EN
		|=> DOUBLE_RATE_CLOCK_OUT == ~ph[`CFRS_PH_DOUBLE_BIT])
		else $error("double-rate clock not realigned after power-down");
	req_low_hold_a: assert property (!RESET_REQ_N |=> RESET_LOCK_OE && !RESET_LOCK_O)
		else $error("reset output released while request low");
	restart_count_a: assert property ($rose(hold) |=> RESET_LOCK_OE && (rel_cnt == 12'h000))
		else $error("release count did not restart");

	lock_reached_c: cover property ($rose(state == LS_LOCK));
	release_seen_c: cover property ($fell(RESET_LOCK_OE));
	request_pulse_c: cover property ((state == LS_LOCK) && $fell(RESET_REQ_N));
	pd_exit_c: cover property ($fell(OUTPUT_POWERDOWN) && (state == LS_LOCK));
	bypass_seen_c: cover property ($rose(state == LS_BYP));

endmodule

// File: verification/cfrs_partner_model.sv
`timescale 1ns/1ps

module cfrs_partner_model (
	input  wire logic       clk,
	input  wire logic [7:0] half_per,
	input  wire logic       lock_oe,
	input  wire logic       lock_o,
	output logic            sync_in,
	output wire             lock_pin
);
	logic [7:0] cnt   = 8'h00;
	logic       ref_q = 1'b0;

	assign sync_in = ref_q;

	// ------------------------------------------------------------
	// free-running reference, toggles every half_per cycles
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (cnt + 8'h01 >= half_per) begin
			cnt <= 8'h00;
			ref_q <= ~ref_q;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	// board pull-up takes the pin high once released
	assign lock_pin = lock_oe ? lock_o : 1'b1;
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps

module testbench;
	import cfrs_pkg::*;
	localparam int REL = 16;
	logic       clk;
	logic       rst;
	logic       loop_en;
	logic       req_n;
	logic       pd;
	logic [7:0] hp;
	logic       sync_in;
	logic [2:0] base;
	logic       inv;
	logic       dbl;
	logic       half;
	logic       rlo;
	logic       rloe;
	wire        pin;
	int         error_cnt;
	int         checks_done;

	cfrs_top #(.RELEASE_CNT(REL)) cfrs_top_inst (
		.REF_CLK(clk), .SYS_RST(rst), .SYNC_IN(sync_in), .LOOP_EN(loop_en),
		.RESET_REQ_N(req_n), .OUTPUT_POWERDOWN(pd), .BASE_CLOCK_OUT(base),
		.INVERTED_CLOCK_OUT(inv), .DOUBLE_RATE_CLOCK_OUT(dbl),
		.HALF_RATE_CLOCK_OUT(half), .RESET_LOCK_O(rlo), .RESET_LOCK_OE(rloe));

	cfrs_partner_model cfrs_partner_model_inst (
		.clk(clk), .half_per(hp), .lock_oe(rloe), .lock_o(rlo),
		.sync_in(sync_in), .lock_pin(pin));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic tick;
		@(posedge clk);
		#1;
	endtask

	task automatic wait_rise;
		logic pb;
		pb = base[2];
		repeat (64) begin
			tick();
			if (base[2] && !pb) return;
			pb = base[2];
		end
		check("base clock running", 16'h0000, 16'h0001);
	endtask

	// counts rising edges over n cycles and checks the fixed relations
	task automatic watch(input int n, input logic pdv, output int rb, output int rd, output int rh);
		logic pb;
		logic pdl;
		logic ph;
		rb = 0;
		rd = 0;
		rh = 0;
		pb = base[2];
		pdl = dbl;
		ph = half;
		repeat (n) begin
			tick();
			check("inverted", inv, !base[2]);
			if (pdv) begin
				check("stopped clocks", {base[1:0], dbl}, 16'h0000);
			end else begin
				check("base copies", base[1:0], {2{base[2]}});
				if (base[2] && !pb) check("double at base rise", dbl, 1'b1);
			end
			rb += int'(base[2] && !pb);
			rd += int'(dbl && !pdl);
			rh += int'(half && !ph);
			pb = base[2];
			pdl = dbl;
			ph = half;
		end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_lock;
		int n;
		n = 0;
		check("pin low before lock", pin, 1'b0);
		while (rloe === 1'b1 && n < 3000) begin
			tick();
			n++;
		end
		check("lock released", rloe, 1'b0);
		check("pin pulled up", pin, 1'b1);
		check("never driven high", rlo, 1'b0);
	endtask

	task automatic t_clocks;
		int rb;
		int rd;
		int rh;
		watch(64, 1'b0, rb, rd, rh);
		check("base rises", 16'(rb), 16'h0008);
		check("double rises", 16'(rd), 16'h0010);
		check("half rises", 16'(rh), 16'h0004);
	endtask

	task automatic t_request(input int low);
		int rises;
		int n;
		logic pb;
		rises = 0;
		n = 0;
		wait_rise();
		@(posedge clk) req_n <= 1'b0;
		repeat (low) @(posedge clk);
		@(posedge clk) req_n <= 1'b1;
		tick();
		check("lock oe held", rloe, 1'b1);
		check("lock pin low", pin, 1'b0);
		pb = base[2];
		while (rloe === 1'b1 && n < 4000) begin
			tick();
			n++;
			if (base[2] && !pb) rises++;
			pb = base[2];
		end
		check("base rises to release", 16'(rises), 16'(REL));
		check("pin released", pin, 1'b1);
	endtask

	task automatic t_powerdown;
		int rb;
		int rd;
		int rh;
		@(posedge clk) pd <= 1'b1;
		repeat (2) tick();
		watch(32, 1'b1, rb, rd, rh);
		check("base2 runs in powerdown", 16'(rb), 16'h0004);
		check("half runs in powerdown", 16'(rh), 16'h0002);
		@(posedge clk) pd <= 1'b0;
		repeat (3) tick();
		watch(32, 1'b0, rb, rd, rh);
		check("double after powerdown", 16'(rd), 16'h0008);
	endtask

	// reset again with the request held low: output stays low past lock
	task automatic t_reset_low;
		int rises;
		int n;
		logic pb;
		rises = 0;
		n = 0;
		@(posedge clk) begin
			rst <= 1'b1;
			req_n <= 1'b0;
		end
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		tick();
		check("pin low after reset", pin, 1'b0);
		repeat (300) tick();
		check("held by low request", rloe, 1'b1);
		check("pin held low", pin, 1'b0);
		wait_rise();
		@(posedge clk) req_n <= 1'b1;
		tick();
		pb = base[2];
		while (rloe === 1'b1 && n < 4000) begin
			tick();
			n++;
			if (base[2] && !pb) rises++;
			pb = base[2];
		end
		check("rises after request rise", 16'(rises), 16'(REL));
		check("pin released again", pin, 1'b1);
	endtask

	task automatic t_bypass;
		logic ps;
		@(posedge clk) begin
			loop_en <= 1'b0;
			hp <= 8'h03;
		end
		repeat (4) tick();
		repeat (24) begin
			ps = sync_in;
			tick();
			check("bypass follows reference", base[2], ps);
		end
		@(posedge clk) begin
			loop_en <= 1'b1;
			hp <= 8'h08;
		end
	endtask

	initial begin
		error_cnt = 0;
		checks_done = 0;
		rst = 1'b1;
		loop_en = 1'b1;
		req_n = 1'b1;
		pd = 1'b0;
		hp = 8'h08;
		tick();
		check("reset clocks", {base, dbl, half, inv, rloe}, 16'h0003);
		@(posedge clk) rst <= 1'b0;
		t_lock();
		t_clocks();
		t_request(0);
		t_request(40);
		t_powerdown();
		t_reset_low();
		t_bypass();
		close_out();
	end

	initial begin
		#300us;
		error_cnt++;
		close_out();
	end
endmodule
